// *** include/uplink_map.svh ***
/*
 * Offsets, counts and timing constants of the uplink port.
 * Assumes the core clock runs at CLK_PERIOD_NS and is included by bare name.
 */
`ifndef UPLINK_MAP_SVH
`define UPLINK_MAP_SVH

`define CLK_PERIOD_NS   100
// half period of the link clock that the port makes itself
`define LINK_HALF_NS    400
`define LINK_HALF_CYC   3'((`LINK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// longest gap between reference edges before the reference counts as lost
`define REF_LOST_NS     2000
`define REF_LOST_CYC    5'((`REF_LOST_NS) / (`CLK_PERIOD_NS))
// reference edges counted before the next one lets the port start working
`define REF_GOOD_EDGES  3'h4
// last count of the slow divider; one di-bit is held ten reference cycles at the slow rate
`define SLOW_HOLD_LAST  4'h9
// units per byte and unit width on each variant
`define MII_UNITS       3'h2
`define RMII_UNITS      3'h4
`define MII_SHIFT       4
`define RMII_SHIFT      2
// core cycles after reset release before the straps are taken
`define STRAP_SETTLE    2'h3

`endif

// *** include/uplink_pkg.sv ***
/*
 * Types shared by the uplink port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package uplink_pkg;
	typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_t;
	typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_DATA = 1'b1} rx_state_t;
endpackage

// *** rtl/pin_sync.sv ***
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes the inputs are quasi-static or slower than the core clock.
 */
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// first stage feeds only the second stage
	always_comb begin
		next_meta = d_i;
		next_q    = meta;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= next_meta;
			q_o  <= next_q;
		end
	end
endmodule // pin_sync

// *** rtl/uplink_port.sv ***
/*
 * Uplink port in MII and RMII variants: byte stream to link units and back.
 * Assumes link clocks far slower than CLK_I, sampled and edge detected here.
 */
// Function
// - MII MAC or PHY role comes from the port-role strap taken at reset.
// - MII PHY role: takes transmit pins, drives both clocks, collision, carrier, receive pins.
// - MII MAC role: drives receive pins, takes clocks, collision, carrier, transmit pins.
// - MII moves one raw nibble per clock each way, clock is quarter bit rate.
// - half duplex MII flags collision when a frame meets another during transmit.
// - RMII runs both 10 and 100 Mbps on the same reference.
// - RMII clock mode makes the reference and drives it on the receive clock.
// - RMII paths are two bits wide and run independently.
// - in normal mode the received reference may clock the whole device.
// - clock-source strap picks shared reference pin or crystal pins for the core.
// - clock or normal mode from port-role strap, overridden by config bit 7.
// - in normal mode the port works only once the reference is present.
// - RMII to a MAC: drive valid and receive data, take enable and data.
// - RMII to a PHY: same pins, swapped meaning by wiring.
// - RMII needs no role setting; wiring alone defines the role.
`include "uplink_map.svh"

module uplink_port
	import uplink_pkg::*;
(
	input  wire logic       CLK_I,
	input  wire logic       RST_B_I,
	input  wire logic       STRAP_PORT_ROLE_I,
	input  wire logic       STRAP_CLOCK_SOURCE_I,
	input  wire logic       RMII_SEL_I,
	input  wire logic       RMII_SLOW_I,
	input  wire logic       HALF_DUPLEX_I,
	input  wire logic       CFG_OVERRIDE_I,
	input  wire logic       CFG_CLOCK_MODE_I,
	input  wire logic       PORT_XMIT_ENABLE_I,
	input  wire logic       PORT_XMIT_ERROR_I,
	input  wire logic [3:0] PORT_XMIT_DATA_I,
	input  wire logic       PORT_XMIT_CLOCK_I,
	output logic            PORT_XMIT_CLOCK_O,
	output logic            PORT_XMIT_CLOCK_OE_B_O,
	input  wire logic       PORT_RECV_CLOCK_I,
	output logic            PORT_RECV_CLOCK_O,
	output logic            PORT_RECV_CLOCK_OE_B_O,
	input  wire logic       PORT_COLLISION_I,
	output logic            PORT_COLLISION_O,
	input  wire logic       PORT_CARRIER_SENSE_I,
	output logic            PORT_CARRIER_SENSE_O,
	output logic            PORT_STATUS_OE_B_O,
	output logic            PORT_RECV_VALID_O,
	output logic            PORT_RECV_ERROR_O,
	output logic [3:0]      PORT_RECV_DATA_O,
	input  wire logic [7:0] EG_DATA_I,
	input  wire logic       EG_ERROR_I,
	input  wire logic       EG_VALID_I,
	output logic            EG_READY_O,
	output logic [7:0]      IN_DATA_O,
	output logic            IN_ERROR_O,
	output logic            IN_VALID_O,
	output logic            IN_FRAME_O,
	output logic            ROLE_PHY_O,
	output logic            CLOCK_MODE_O,
	output logic            CORE_CLK_FROM_REF_O,
	output logic            REF_READY_O,
	output logic            COLLISION_SEEN_O
);
	logic [1:0] clk_s;
	logic [9:0] pin_s;
	logic       xc_s, rc_s, strap_role_s, strap_clk_s, xen_s, xer_s, col_s, crs_s;
	logic [3:0] xd_s;

	pin_sync #(.W(2)) u_clk_sync (
		.clk_i   (CLK_I),
		.rst_b_i (RST_B_I),
		.d_i     ({PORT_RECV_CLOCK_I, PORT_XMIT_CLOCK_I}),
		.q_o     (clk_s)
	);
	pin_sync #(.W(10)) u_pin_sync (
		.clk_i   (CLK_I),
		.rst_b_i (RST_B_I),
		.d_i     ({STRAP_PORT_ROLE_I, STRAP_CLOCK_SOURCE_I, PORT_XMIT_ENABLE_I,
		           PORT_XMIT_ERROR_I, PORT_XMIT_DATA_I, PORT_COLLISION_I,
		           PORT_CARRIER_SENSE_I}),
		.q_o     (pin_s)
	);
	assign {rc_s, xc_s} = clk_s;
	assign {strap_role_s, strap_clk_s, xen_s, xer_s, xd_s, col_s, crs_s} = pin_s;

	// clocking and mode state
	logic [1:0] strap_cnt, next_strap_cnt;
	logic       strap_done, next_strap_done, next_role, next_core_src;
	logic [2:0] gen_cnt, next_gen_cnt;
	logic       next_gen_clk, xc_prev, rc_prev;
	logic [2:0] ref_edges, next_ref_edges;
	logic [4:0] ref_gap, next_ref_gap;
	logic       next_ref_ok, next_clock_mode, next_xc_oe_b, next_rc_oe_b, next_st_oe_b;
	logic       gen_rise, xc_rise, rc_rise, use_gen, tx_tick, rx_tick;

	assign gen_rise = (gen_cnt == `LINK_HALF_CYC - 3'h1) && !PORT_XMIT_CLOCK_O;
	assign xc_rise  = xc_s && !xc_prev;
	assign rc_rise  = rc_s && !rc_prev;
	assign use_gen  = RMII_SEL_I ? CLOCK_MODE_O : ROLE_PHY_O;
	assign rx_tick  = use_gen ? gen_rise : xc_rise;
	assign tx_tick  = use_gen ? gen_rise : (RMII_SEL_I ? xc_rise : rc_rise);

	// strap capture, clock divider, reference watch and pin directions
	always_comb begin
		next_strap_cnt  = strap_cnt;
		next_strap_done = strap_done;
		next_role       = ROLE_PHY_O;
		next_core_src   = CORE_CLK_FROM_REF_O;
		if (!strap_done) begin
			next_strap_cnt = strap_cnt + 2'h1;
			if (strap_cnt == `STRAP_SETTLE) begin
				next_strap_done = 1'b1;
				next_role       = strap_role_s;
				next_core_src   = strap_clk_s;
			end
		end
		next_gen_cnt = (gen_cnt == `LINK_HALF_CYC - 3'h1) ? 3'h0 : gen_cnt + 3'h1;
		next_gen_clk = (gen_cnt == `LINK_HALF_CYC - 3'h1) ? !PORT_XMIT_CLOCK_O
		                                                   : PORT_XMIT_CLOCK_O;
		next_clock_mode = CFG_OVERRIDE_I ? CFG_CLOCK_MODE_I : ROLE_PHY_O;
		next_ref_edges  = ref_edges;
		next_ref_gap    = ref_gap;
		next_ref_ok     = REF_READY_O;
		if (use_gen) begin
			next_ref_edges = 3'h0;
			next_ref_gap   = 5'h0;
			next_ref_ok    = strap_done;
		end else if (xc_rise) begin
			next_ref_gap = 5'h0;
			if (ref_edges != `REF_GOOD_EDGES)
				next_ref_edges = ref_edges + 3'h1;
			else
				next_ref_ok = strap_done;
		end else if (ref_gap == `REF_LOST_CYC) begin
			next_ref_edges = 3'h0;
			next_ref_ok    = 1'b0;
		end else begin
			next_ref_gap = ref_gap + 5'h1;
		end
		// PHY role drives both MII clocks; clock mode drives the reference out
		next_xc_oe_b = !(strap_done && !RMII_SEL_I && ROLE_PHY_O);
		next_rc_oe_b = !(strap_done && (RMII_SEL_I ? CLOCK_MODE_O : ROLE_PHY_O));
		next_st_oe_b = next_xc_oe_b;
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			strap_cnt              <= 2'h0;
			strap_done             <= 1'b0;
			ROLE_PHY_O             <= 1'b0;
			CORE_CLK_FROM_REF_O    <= 1'b0;
			gen_cnt                <= 3'h0;
			PORT_XMIT_CLOCK_O      <= 1'b0;
			PORT_RECV_CLOCK_O      <= 1'b0;
			xc_prev                <= 1'b0;
			rc_prev                <= 1'b0;
			ref_edges              <= 3'h0;
			ref_gap                <= 5'h0;
			REF_READY_O            <= 1'b0;
			CLOCK_MODE_O           <= 1'b0;
			PORT_XMIT_CLOCK_OE_B_O <= 1'b1;
			PORT_RECV_CLOCK_OE_B_O <= 1'b1;
			PORT_STATUS_OE_B_O     <= 1'b1;
		end else begin
			strap_cnt              <= next_strap_cnt;
			strap_done             <= next_strap_done;
			ROLE_PHY_O             <= next_role;
			CORE_CLK_FROM_REF_O    <= next_core_src;
			gen_cnt                <= next_gen_cnt;
			PORT_XMIT_CLOCK_O      <= next_gen_clk;
			PORT_RECV_CLOCK_O      <= next_gen_clk;
			xc_prev                <= xc_s;
			rc_prev                <= rc_s;
			ref_edges              <= next_ref_edges;
			ref_gap                <= next_ref_gap;
			REF_READY_O            <= next_ref_ok;
			CLOCK_MODE_O           <= next_clock_mode;
			PORT_XMIT_CLOCK_OE_B_O <= next_xc_oe_b;
			PORT_RECV_CLOCK_OE_B_O <= next_rc_oe_b;
			PORT_STATUS_OE_B_O     <= next_st_oe_b;
		end
	end

	// transmit path: byte holding stage, then units out on each step
	tx_state_t  tx_state, next_tx_state;
	logic [7:0] tx_shift, next_tx_shift, hold_data, next_hold_data;
	logic [2:0] tx_cnt, next_tx_cnt;
	logic [3:0] tx_div, next_tx_div;
	logic       tx_err, next_tx_err, hold_err, next_hold_err, hold_full, next_hold_full;
	logic       next_eg_ready, next_valid, next_err, tx_step, slow;
	logic [3:0] next_data;

	assign slow    = RMII_SEL_I && RMII_SLOW_I;
	assign tx_step = tx_tick && REF_READY_O && (!slow || tx_div == 4'h0);

	always_comb begin
		next_tx_state  = tx_state;
		next_tx_shift  = tx_shift;
		next_tx_cnt    = tx_cnt;
		next_tx_err    = tx_err;
		next_hold_data = hold_data;
		next_hold_err  = hold_err;
		next_hold_full = hold_full;
		next_valid     = PORT_RECV_VALID_O;
		next_err       = PORT_RECV_ERROR_O;
		next_data      = PORT_RECV_DATA_O;
		next_tx_div    = tx_div;
		if (tx_tick)
			next_tx_div = (!slow || tx_div == `SLOW_HOLD_LAST) ? 4'h0 : tx_div + 4'h1;
		if (EG_VALID_I && EG_READY_O) begin
			next_hold_data = EG_DATA_I;
			next_hold_err  = EG_ERROR_I;
			next_hold_full = 1'b1;
		end
		if (tx_step) begin
			if (tx_cnt != 3'h0) begin
				next_data     = RMII_SEL_I ? {2'h0, tx_shift[1:0]} : tx_shift[3:0];
				next_tx_shift = RMII_SEL_I ? tx_shift >> `RMII_SHIFT : tx_shift >> `MII_SHIFT;
				next_tx_cnt   = tx_cnt - 3'h1;
				next_err      = tx_err;
			end else if (hold_full) begin
				next_tx_state  = TX_SEND;
				next_valid     = 1'b1;
				next_err       = hold_err;
				next_tx_err    = hold_err;
				next_data      = RMII_SEL_I ? {2'h0, hold_data[1:0]} : hold_data[3:0];
				next_tx_shift  = RMII_SEL_I ? hold_data >> `RMII_SHIFT
				                            : hold_data >> `MII_SHIFT;
				next_tx_cnt    = (RMII_SEL_I ? `RMII_UNITS : `MII_UNITS) - 3'h1;
				next_hold_full = EG_VALID_I && EG_READY_O;
			end else begin
				next_tx_state = TX_IDLE;
				next_valid    = 1'b0;
				next_err      = 1'b0;
				next_data     = 4'h0;
			end
		end
		next_eg_ready = !next_hold_full;
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			tx_state          <= TX_IDLE;
			tx_shift          <= 8'h00;
			tx_cnt            <= 3'h0;
			tx_err            <= 1'b0;
			tx_div            <= 4'h0;
			hold_data         <= 8'h00;
			hold_err          <= 1'b0;
			hold_full         <= 1'b0;
			EG_READY_O        <= 1'b0;
			PORT_RECV_VALID_O <= 1'b0;
			PORT_RECV_ERROR_O <= 1'b0;
			PORT_RECV_DATA_O  <= 4'h0;
		end else begin
			tx_state          <= next_tx_state;
			tx_shift          <= next_tx_shift;
			tx_cnt            <= next_tx_cnt;
			tx_err            <= next_tx_err;
			tx_div            <= next_tx_div;
			hold_data         <= next_hold_data;
			hold_err          <= next_hold_err;
			hold_full         <= next_hold_full;
			EG_READY_O        <= next_eg_ready;
			PORT_RECV_VALID_O <= next_valid;
			PORT_RECV_ERROR_O <= next_err;
			PORT_RECV_DATA_O  <= next_data;
		end
	end

	// receive path: units in on each step, byte out when complete
	rx_state_t  rx_state, next_rx_state;
	logic [7:0] rx_shift, next_rx_shift, next_in_data;
	logic [2:0] rx_cnt, next_rx_cnt;
	logic [3:0] rx_div, next_rx_div;
	logic       rx_err, next_rx_err, next_in_valid, next_in_err, rx_step;
	logic       next_col, next_crs, next_col_seen;

	// the frame's first unit restarts the slow divider so the hold aligns to it
	assign rx_step = rx_tick && REF_READY_O && (!slow || rx_div == 4'h0 || rx_state == RX_IDLE);

	always_comb begin
		next_rx_state = rx_state;
		next_rx_shift = rx_shift;
		next_rx_cnt   = rx_cnt;
		next_rx_err   = rx_err;
		next_rx_div   = rx_div;
		next_in_data  = IN_DATA_O;
		next_in_err   = IN_ERROR_O;
		next_in_valid = 1'b0;
		if (rx_tick)
			next_rx_div = (!slow || rx_div == `SLOW_HOLD_LAST || rx_step) ?
			              ((slow && rx_step) ? 4'h1 : 4'h0) : rx_div + 4'h1;
		if (rx_step) begin
			if (xen_s) begin
				next_rx_state = RX_DATA;
				// low unit arrives first and ends at the bottom of the byte
				next_rx_shift = RMII_SEL_I ? {xd_s[1:0], rx_shift[7:2]}
				                           : {xd_s, rx_shift[7:4]};
				next_rx_err   = rx_err || xer_s;
				if (rx_cnt == (RMII_SEL_I ? `RMII_UNITS : `MII_UNITS) - 3'h1) begin
					next_in_data  = next_rx_shift;
					next_in_err   = next_rx_err;
					next_in_valid = 1'b1;
					next_rx_cnt   = 3'h0;
					next_rx_err   = 1'b0;
				end else begin
					next_rx_cnt = rx_cnt + 3'h1;
				end
			end else begin
				// a trailing part byte is dropped
				next_rx_state = RX_IDLE;
				next_rx_cnt   = 3'h0;
				next_rx_err   = 1'b0;
			end
		end
		// PHY role reports the medium toward the external MAC
		next_crs      = (tx_state == TX_SEND) || xen_s;
		next_col      = HALF_DUPLEX_I && (tx_state == TX_SEND) && xen_s;
		next_col_seen = ROLE_PHY_O ? next_col : (!RMII_SEL_I && col_s && crs_s);
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rx_state             <= RX_IDLE;
			rx_shift             <= 8'h00;
			rx_cnt               <= 3'h0;
			rx_err               <= 1'b0;
			rx_div               <= 4'h0;
			IN_DATA_O            <= 8'h00;
			IN_ERROR_O           <= 1'b0;
			IN_VALID_O           <= 1'b0;
			IN_FRAME_O           <= 1'b0;
			PORT_CARRIER_SENSE_O <= 1'b0;
			PORT_COLLISION_O     <= 1'b0;
			COLLISION_SEEN_O     <= 1'b0;
		end else begin
			rx_state             <= next_rx_state;
			rx_shift             <= next_rx_shift;
			rx_cnt               <= next_rx_cnt;
			rx_err               <= next_rx_err;
			rx_div               <= next_rx_div;
			IN_DATA_O            <= next_in_data;
			IN_ERROR_O           <= next_in_err;
			IN_VALID_O           <= next_in_valid;
			IN_FRAME_O           <= next_rx_state == RX_DATA;
			PORT_CARRIER_SENSE_O <= next_crs;
			PORT_COLLISION_O     <= next_col;
			COLLISION_SEEN_O     <= next_col_seen;
		end
	end

	// checks on the port's own behaviour
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);

	a_strap_held: assert property (strap_done |=> $stable(ROLE_PHY_O) && $stable(CORE_CLK_FROM_REF_O)) else $error("strap changed");
	a_phy_clk_out: assert property (strap_done && !RMII_SEL_I && ROLE_PHY_O |=> !PORT_XMIT_CLOCK_OE_B_O && !PORT_STATUS_OE_B_O) else $error("phy role not driving");
	a_mac_clk_in: assert property (strap_done && !RMII_SEL_I && !ROLE_PHY_O |=> PORT_XMIT_CLOCK_OE_B_O && PORT_RECV_CLOCK_OE_B_O) else $error("mac role driving clock");
	a_ref_out: assert property (strap_done && RMII_SEL_I && CLOCK_MODE_O |=> !PORT_RECV_CLOCK_OE_B_O && PORT_XMIT_CLOCK_OE_B_O) else $error("reference not driven");
	a_override: assert property (CFG_OVERRIDE_I |=> CLOCK_MODE_O == $past(CFG_CLOCK_MODE_I)) else $error("override ignored");
	a_ref_gate: assert property (!REF_READY_O |=> $stable(PORT_RECV_DATA_O) && $stable(PORT_RECV_VALID_O)) else $error("sent without reference");
	a_low_first: assert property (tx_step && tx_cnt == 3'h0 && hold_full && !RMII_SEL_I |=> PORT_RECV_VALID_O && PORT_RECV_DATA_O == $past(hold_data[3:0])) else $error("high nibble first");
	a_collision: assert property (HALF_DUPLEX_I && tx_state == TX_SEND && xen_s |=> PORT_COLLISION_O) else $error("collision missed");
	a_slow_hold: assert property (slow && $changed(PORT_RECV_DATA_O) |=> $stable(PORT_RECV_DATA_O) [*8]) else $error("di-bit held too short");
	a_rx_count: assert property (IN_VALID_O && !RMII_SEL_I |-> $past(rx_cnt) == 3'h1) else $error("mii byte not two nibbles");

	c_frame_sent: cover property ($fell(PORT_RECV_VALID_O));
	c_byte_in: cover property (IN_VALID_O && RMII_SEL_I);
	c_collision: cover property (PORT_COLLISION_O);
	c_ref_up: cover property ($rose(REF_READY_O) && RMII_SEL_I);
endmodule // uplink_port

// *** test/link_partner.sv ***
/*
 * Far-side model of the uplink port: an external MAC or PHY.
 * Assumes the bench resolves the shared clock pins and hands in the link clock.
 */
module link_partner (
	input  wire logic       lclk_i,
	input  wire logic       rmii_i,
	input  wire logic       slow_i,
	input  wire logic       run_i,
	input  wire logic       valid_i,
	input  wire logic [3:0] data_i,
	output logic            pclk_o,
	output logic            en_o,
	output logic            err_o,
	output logic [3:0]      data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] txq[$];
	logic [7:0] rxq[$];
	logic [7:0] acc;
	int         k;
	int         t;

	// own free-running clock, withheld only while the bench stops it
	initial begin
		pclk_o = 1'b0;
		#137;
		forever begin
			#400;
			if (run_i) pclk_o = ~pclk_o;
		end
	end

	// sends queued bytes at mid-period, enable low and data churning between frames
	initial begin : send
		logic [8:0] b;
		en_o = 1'b0;
		err_o = 1'b0;
		data_o = 4'h5;
		forever begin
			if (txq.size() == 0) begin
				en_o <= 1'b0;
				err_o <= 1'b0;
				data_o <= ~data_o;
				@(negedge lclk_i);
			end else begin
				b = txq.pop_front();
				for (int u = 0; u < (rmii_i ? 4 : 2); u++) begin
					en_o <= 1'b1;
					err_o <= b[8];
					data_o <= 4'(b[7:0] >> ((rmii_i ? 2 : 4) * u));
					repeat (slow_i ? 10 : 1) @(negedge lclk_i);
				end
			end
		end
	end

	// collects device units low first; the device's error output is left unheard
	always @(negedge lclk_i) begin
		if (valid_i !== 1'b1) begin
			k = 0;
			t = 0;
		end else begin
			if (t == 0) begin
				acc = rmii_i ? {data_i[1:0], acc[7:2]} : {data_i, acc[7:4]};
				k++;
				if (k == (rmii_i ? 4 : 2)) begin
					rxq.push_back(acc);
					k = 0;
				end
			end
			t = (slow_i && t != 9) ? t + 1 : 0;
		end
	end
endmodule // link_partner

// *** test/tb.sv ***
/*
 * Self-checking bench of the uplink port across MII and RMII settings.
 * Assumes the link partner model and a 10 MHz core clock.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       strap = 1'b0;
	logic       src = 1'b0;
	logic       rmii = 1'b0;
	logic       slow = 1'b0;
	logic       half = 1'b0;
	logic       ovr = 1'b0;
	logic       cfg = 1'b0;
	logic       run = 1'b1;
	logic [7:0] eg_data = 8'h00;
	logic       eg_valid = 1'b0;
	logic       eg_err = 1'b0;
	wire logic  eg_ready, xoe, roe, soe, xclk_o, rclk_o, pclk, lclk, xpin, rpin;
	wire logic  p_en, p_err, r_valid, col, crs, in_valid, in_err, role, cmode;
	wire logic  from_ref, ref_ready, r_err, in_frame, col_rep, pcol, pcrs;
	wire logic [3:0] p_data, r_data;
	wire logic [7:0] in_data;
	logic [8:0] got[$];
	logic [8:0] in_exp[$];
	logic [7:0] eg_exp[$];
	logic       col_seen, crs_seen, hi_seen, err_seen, frame_seen, rep_seen;
	int         seed = 32'hE793;
	int         n_mismatch = 0;
	int         checks_done = 0;
	logic [5:0] cfg_tab[6] = '{6'h09, 6'h01, 6'h28, 6'h3C, 6'h26, 6'h20};

	// shared clock pins resolve to whoever drives them; partner follows the receive clock
	assign xpin = xoe ? pclk : xclk_o;
	assign rpin = roe ? pclk : rclk_o;
	assign lclk = rpin;
	// partner as a phy: carrier while either side sends, collision when both do in half duplex
	assign pcrs = p_en || r_valid;
	assign pcol = half && p_en && r_valid;

	uplink_port i_dut (.CLK_I(clk), .RST_B_I(rst_b), .STRAP_PORT_ROLE_I(strap),
		.STRAP_CLOCK_SOURCE_I(src), .RMII_SEL_I(rmii), .RMII_SLOW_I(slow),
		.HALF_DUPLEX_I(half), .CFG_OVERRIDE_I(ovr), .CFG_CLOCK_MODE_I(cfg),
		.PORT_XMIT_ENABLE_I(p_en), .PORT_XMIT_ERROR_I(p_err), .PORT_XMIT_DATA_I(p_data),
		.PORT_XMIT_CLOCK_I(xpin), .PORT_XMIT_CLOCK_O(xclk_o), .PORT_XMIT_CLOCK_OE_B_O(xoe),
		.PORT_RECV_CLOCK_I(rpin), .PORT_RECV_CLOCK_O(rclk_o), .PORT_RECV_CLOCK_OE_B_O(roe),
		.PORT_COLLISION_I(pcol), .PORT_COLLISION_O(col), .PORT_CARRIER_SENSE_I(pcrs),
		.PORT_CARRIER_SENSE_O(crs), .PORT_STATUS_OE_B_O(soe), .PORT_RECV_VALID_O(r_valid),
		.PORT_RECV_ERROR_O(r_err), .PORT_RECV_DATA_O(r_data), .EG_DATA_I(eg_data),
		.EG_ERROR_I(eg_err), .EG_VALID_I(eg_valid), .EG_READY_O(eg_ready),
		.IN_DATA_O(in_data), .IN_ERROR_O(in_err), .IN_VALID_O(in_valid),
		.IN_FRAME_O(in_frame),
		.ROLE_PHY_O(role), .CLOCK_MODE_O(cmode), .CORE_CLK_FROM_REF_O(from_ref),
		.REF_READY_O(ref_ready), .COLLISION_SEEN_O(col_rep));

	link_partner i_partner (.lclk_i(lclk), .rmii_i(rmii), .slow_i(slow), .run_i(run),
		.valid_i(r_valid), .data_i(r_data), .pclk_o(pclk), .en_o(p_en), .err_o(p_err),
		.data_o(p_data));

	// core clock, 100 ns period
	initial begin
		forever #50 clk = ~clk;
	end

	// collects received bytes and watches status pins
	always @(posedge clk) begin
		if (in_valid === 1'b1) got.push_back({in_err, in_data});
		// status pins count only while driven; released they still show the port's own level
		if (col === 1'b1 && soe === 1'b0) col_seen = 1'b1;
		if (crs === 1'b1 && soe === 1'b0) crs_seen = 1'b1;
		if (r_valid === 1'b1 && r_err === 1'b1) err_seen = 1'b1;
		if (in_frame === 1'b1) frame_seen = 1'b1;
		if (col_rep === 1'b1) rep_seen = 1'b1;
		if (rmii && r_valid === 1'b1 && r_data[3:2] !== 2'h0) hi_seen = 1'b1;
	end

	// compares one value and counts the outcome
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// prints the verdict and ends the run
	task automatic stop_test();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one setting: reset, straps, pin directions, then traffic both ways at once
	task automatic run_cfg(input logic [5:0] c);
		logic       cm;
		logic       mii_phy;
		logic [8:0] b;
		logic [7:0] d;
		int         n;
		cm = c[2] ? c[1] : c[3];
		mii_phy = !c[5] && c[3];
		@(posedge clk);
		{rmii, slow, strap, ovr, cfg, half} <= c;
		src <= 1'($random(seed));
		run <= (c != 6'h20);
		rst_b <= 1'b0;
		repeat (5) @(posedge clk);
		check("reset pins", 9'({xoe, roe, soe, eg_ready, r_valid}), 9'h1C);
		rst_b <= 1'b1;
		repeat (40) @(posedge clk);
		if (!run) begin
			check("ref absent", 9'(ref_ready), 9'h000);
			run <= 1'b1;
		end
		repeat (60) @(posedge clk);
		check("ref ready", 9'(ref_ready), 9'h001);
		check("role", 9'(role), 9'(strap));
		check("clock source", 9'(from_ref), 9'(src));
		check("recv clock oe", 9'(roe), 9'(!(mii_phy || (rmii && cm))));
		if (rmii) check("clock mode", 9'(cmode), 9'(cm));
		if (!rmii) check("mii oe", 9'({xoe, soe}), 9'({2{!strap}}));
		got.delete();
		in_exp.delete();
		eg_exp.delete();
		i_partner.rxq.delete();
		col_seen = 1'b0;
		crs_seen = 1'b0;
		hi_seen = 1'b0;
		err_seen = 1'b0;
		frame_seen = 1'b0;
		rep_seen = 1'b0;
		for (int i = 0; i < 4; i++) begin
			b = {($random(seed) & 3) == 0, 8'($random(seed))};
			in_exp.push_back(b);
			i_partner.txq.push_back(b);
		end
		for (int i = 0; i < 4; i++) begin
			d = (i == 0) ? 8'hFF : (i == 3) ? 8'h00 : 8'($random(seed));
			eg_exp.push_back(d);
			eg_valid <= 1'b1;
			eg_data <= d;
			eg_err <= (i == 2);
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (eg_ready !== 1'b1 && n < 2000);
		end
		eg_valid <= 1'b0;
		eg_err <= 1'b0;
		n = 0;
		while ((got.size() < 4 || i_partner.rxq.size() < 4) && n < 4000) begin
			@(posedge clk);
			n++;
		end
		for (int i = 0; i < 4; i++) begin
			check("ingress byte", got[i], in_exp[i]);
			check("egress byte", 9'(i_partner.rxq[i]), 9'(eg_exp[i]));
		end
		check("collision", 9'(col_seen), 9'(mii_phy && c[0]));
		check("carrier", 9'(crs_seen), 9'(mii_phy));
		check("rmii upper", 9'(hi_seen), 9'h000);
		check("traffic done", 9'(n < 4000), 9'h001);
		check("recv error", 9'(err_seen), 9'h001);
		check("in frame", 9'(frame_seen), 9'h001);
		check("collision report", 9'(rep_seen), 9'(!c[5] && c[0]));
	endtask

	// walks every setting of the table
	initial begin
		for (int c = 0; c < 6; c++) run_cfg(cfg_tab[c]);
		stop_test();
	end

	// cuts a hang short well beyond the longest expected run
	initial begin
		#5000000;
		n_mismatch++;
		stop_test();
	end
endmodule // tb
